// *** shared/pcm_map.svh ***
`ifndef PCM_MAP_SVH
`define PCM_MAP_SVH

// command codes (register offsets)
`define PCM_CMD_STRAP_STATUS  8'h11
`define PCM_CMD_MODE          8'h12
`define PCM_CMD_DET_CLASS_EN  8'h14
`define PCM_CMD_RESET         8'h1A
`define PCM_CMD_POWER_ALLOC   8'h29

// reset values
`define PCM_MODE_RESET        8'h00
`define PCM_EN_RESET          8'h00
`define PCM_ALLOC_RESET       8'h00

// strap status field positions
`define PCM_STRAP_ADDR_LSB    3
`define PCM_STRAP_GROUP_BIT   2

// reset register field positions
`define PCM_RESET_ALL_BIT     7
`define PCM_PORT_RESET_MSB    3

// channel mode encodings
`define PCM_MODE_OFF          2'b00
`define PCM_MODE_MANUAL       2'b01
`define PCM_MODE_SEMI         2'b10
`define PCM_MODE_AUTO         2'b11

// autonomous select strap encodings and register presets
`define PCM_AUTO_OPEN         2'b00
`define PCM_AUTO_124K         2'b01
`define PCM_AUTO_62K          2'b10
`define PCM_AUTO_MODE_PRESET  8'hFF
`define PCM_AUTO_EN_PRESET    8'hFF
`define PCM_AUTO_ALLOC_30W    8'h33

// seven-bit slave address: fixed high bits and broadcast
`define PCM_ADDR_PREFIX       2'b01
`define PCM_ADDR_BROADCAST    7'h7F

// pin synchroniser: idle levels and cycles before the strap sample
`define PCM_PIN_IDLE          11'h700
`define PCM_STARTUP_CYCLES    3'h6

`endif

// *** shared/pcm_pkg.sv ***
package pcm_pkg;

  typedef enum logic [3:0] {
    IDLE,
    ADDR,
    ADDR_ACK,
    CMD,
    CMD_ACK,
    WDATA,
    WDATA_ACK,
    RDATA,
    RDATA_ACK
  } pcm_i2c_state_t;

  typedef logic [1:0] pcm_mode_t;

endpackage

// *** core/pcm_mode_control.sv ***
`timescale 1ns/1ps
`include "pcm_map.svh"

// Contract
// RULE_01: strap status register at 11h shows address pins in bits 6..3.
// RULE_02: bit 2 is the channel group bit: 0 channels 1-4, 1 channels 5-8.
// RULE_03: group bit reads 0 in configuration B, strapped value in configuration A.
// RULE_04: autonomous mode runs ports in auto discovery without any host traffic.
// RULE_05: autonomous strap presets mode, enable and allocation registers per table.
// RULE_06: over-class loads still powered, limited to the autonomous allocation.
// RULE_07: bus and all registers stay fully usable while autonomous.
// RULE_08: autonomous strap sampled only at power-up, never after soft resets.
// RULE_09: ROM device in autonomous mode turns ports off, then resumes automatically.
// RULE_10: SRAM device in autonomous mode keeps ports off until host re-enables.
// RULE_11: host programs SRAM before leaving autonomous mode.
// RULE_12: mode register at 12h, two bits per channel, reset zero.
// RULE_13: OFF channel gets no power, detection or classification.
// RULE_14: entering OFF clears event, fault and power status bits of that channel.
// RULE_15: entering OFF clears enables, results, measurements and class of channel.
// RULE_16: entering OFF sets that channel's policing register to all ones.
// RULE_17: OFF clearing touches only the switched channel.
// RULE_18: PG or PE falling by clearing sets matching change events.
// RULE_19: semiauto to manual or OFF cancels running cooldown.
// RULE_20: slave address is 01, pins, group bit; broadcast address always accepted.
// RULE_21: writes to strap status ignored; reads give current strap content.
module pcm_mode_control #(
  parameter int NCH = 4
) (
  input  wire logic                  CLK_I,
  input  wire logic                  RST_I,
  input  wire logic                  SCL_I,
  input  wire logic                  SDA_I,
  output logic                       SDA_O,
  output logic                       SDA_OE_O,
  input  wire logic                  RESET_PIN_N_I,
  input  wire logic [3:0]            ADDR_PIN_I,
  input  wire logic                  GROUP_STRAP_I,
  input  wire logic                  CONFIG_A_I,
  input  wire logic [1:0]            AUTO_SEL_I,
  input  wire logic                  SRAM_PROGRAMMED_I,
  input  wire logic [NCH-1:0]        POWER_GOOD_I,
  input  wire logic [NCH-1:0]        POWER_ENABLED_I,
  output pcm_pkg::pcm_mode_t [NCH-1:0] MODE_O,
  output logic [2*NCH-1:0]           DET_CLASS_EN_O,
  output logic [7:0]                 POWER_ALLOC_O,
  output logic                       AUTONOMOUS_O,
  output logic [NCH-1:0]             PORT_ACTIVE_O,
  output logic [NCH-1:0]             OFF_CLEAR_O,
  output logic [2*NCH-1:0]           POWER_EVENT_SET_O,
  output logic [NCH-1:0]             COOLDOWN_CANCEL_O
);
  import pcm_pkg::*;

  // three-stage pin synchroniser, level taken once stages two and three agree
  logic [10:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_flt_reg;
  wire  [10:0] pin_raw = {SCL_I, SDA_I, RESET_PIN_N_I, ADDR_PIN_I, GROUP_STRAP_I, CONFIG_A_I, AUTO_SEL_I};
  wire  [10:0] pin_agree = pin_s2_reg ~^ pin_s3_reg;
  wire  [10:0] pin_flt_next = (pin_agree & pin_s3_reg) | (~pin_agree & pin_flt_reg);

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      pin_s1_reg  <= `PCM_PIN_IDLE;
      pin_s2_reg  <= `PCM_PIN_IDLE;
      pin_s3_reg  <= `PCM_PIN_IDLE;
      pin_flt_reg <= `PCM_PIN_IDLE;
    end
    else
    begin
      pin_s1_reg  <= pin_raw;
      pin_s2_reg  <= pin_s1_reg;
      pin_s3_reg  <= pin_s2_reg;
      pin_flt_reg <= pin_flt_next;
    end
  end

  // filtered pin levels and bus edges
  logic scl_d_reg, sda_d_reg, rstpin_d_reg;
  wire       scl      = pin_flt_reg[10];
  wire       sda      = pin_flt_reg[9];
  wire       rstpin_n = pin_flt_reg[8];
  wire [3:0] addr_pin = pin_flt_reg[7:4];
  wire       group    = pin_flt_reg[2] ? pin_flt_reg[3] : 1'b0; // RULE_03
  wire [1:0] auto_sel = pin_flt_reg[1:0];
  wire scl_rise  = scl & ~scl_d_reg;
  wire scl_fall  = ~scl & scl_d_reg;
  wire bus_start = scl & scl_d_reg & ~sda & sda_d_reg;
  wire bus_stop  = scl & scl_d_reg & sda & ~sda_d_reg;
  wire rstpin_assert = ~rstpin_n & rstpin_d_reg;

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      rstpin_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg    <= scl;
      sda_d_reg    <= sda;
      rstpin_d_reg <= rstpin_n;
    end
  end

  // register state
  logic [2*NCH-1:0] mode_reg, mode_next;
  logic [2*NCH-1:0] en_reg, en_next;
  logic [7:0]       alloc_reg, alloc_next;
  logic [1:0]       auto_cfg_reg;
  logic             sampled_reg;
  logic [2:0]       startup_reg;
  logic [NCH-1:0]   resume_reg;

  // strap content, live from the pins
  wire [7:0] strap_status = {1'b0, addr_pin, group, 2'b00}; // RULE_01 RULE_02
  wire [6:0] own_addr = {`PCM_ADDR_PREFIX, addr_pin, group};

  // read decode, also used to load the transmit shifter
  function automatic logic [7:0] reg_read(input logic [7:0] cmd);
    logic [7:0] v;
    v = 8'h00;
    unique case (cmd)
      `PCM_CMD_STRAP_STATUS: v = strap_status; // RULE_21
      `PCM_CMD_MODE:         v = mode_reg[7:0]; // RULE_12
      `PCM_CMD_DET_CLASS_EN: v = en_reg[7:0];
      `PCM_CMD_POWER_ALLOC:  v = alloc_reg;
      default:               v = 8'h00;
    endcase
    return v;
  endfunction

  // i2c slave: address, command byte, then data bytes with auto increment
  pcm_i2c_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg, ptr_reg, wr_data_reg, wr_addr_reg;
  logic       rw_reg, wr_stb_reg, mack_reg;
  wire  [7:0] shift_in = {shift_reg[6:0], sda};
  wire        addr_hit = (shift_reg[7:1] == own_addr) || (shift_reg[7:1] == `PCM_ADDR_BROADCAST); // RULE_20
  wire  [7:0] rd_byte  = reg_read(ptr_reg);

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_reg   <= IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      ptr_reg     <= 8'h00;
      rw_reg      <= 1'b0;
      mack_reg    <= 1'b0;
      wr_stb_reg  <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      SDA_OE_O    <= 1'b0;
      SDA_O       <= 1'b0;
    end
    else
    begin
      wr_stb_reg <= 1'b0;
      if (bus_start)
      begin
        state_reg   <= ADDR;
        bit_cnt_reg <= 4'h0;
        SDA_OE_O    <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg <= IDLE;
        SDA_OE_O  <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (state_reg == ADDR || state_reg == CMD || state_reg == WDATA)
        begin
          shift_reg   <= shift_in;
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (state_reg == RDATA_ACK)
          mack_reg <= ~sda;
      end
      else if (scl_fall)
      begin
        unique case (state_reg)
          IDLE: ;
          ADDR:
          begin
            if (bit_cnt_reg == 4'h8)
            begin
              state_reg <= addr_hit ? ADDR_ACK : IDLE;
              SDA_OE_O  <= addr_hit;
              rw_reg    <= shift_reg[0];
            end
          end
          ADDR_ACK, RDATA_ACK:
          begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == ADDR_ACK && !rw_reg)
            begin
              state_reg <= CMD;
              SDA_OE_O  <= 1'b0;
            end
            else if (state_reg == RDATA_ACK && !mack_reg)
            begin
              state_reg <= IDLE;
              SDA_OE_O  <= 1'b0;
            end
            else
            begin
              state_reg <= RDATA;
              tx_reg    <= rd_byte;
              SDA_OE_O  <= ~rd_byte[7];
            end
          end
          CMD, WDATA:
          begin
            if (bit_cnt_reg == 4'h8)
            begin
              state_reg <= (state_reg == CMD) ? CMD_ACK : WDATA_ACK;
              SDA_OE_O  <= 1'b1;
              if (state_reg == CMD)
                ptr_reg <= shift_reg;
              else
              begin
                wr_stb_reg  <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= shift_reg;
              end
            end
          end
          CMD_ACK, WDATA_ACK:
          begin
            state_reg   <= WDATA;
            bit_cnt_reg <= 4'h0;
            SDA_OE_O    <= 1'b0;
            if (state_reg == WDATA_ACK)
              ptr_reg <= ptr_reg + 8'h01;
          end
          RDATA:
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            tx_reg      <= {tx_reg[6:0], 1'b0};
            if (bit_cnt_reg == 4'h7)
            begin
              state_reg <= RDATA_ACK;
              SDA_OE_O  <= 1'b0;
              ptr_reg   <= ptr_reg + 8'h01;
            end
            else
              SDA_OE_O <= ~tx_reg[6];
          end
        endcase
      end
    end
  end

  // write decode and soft reset sources
  wire wr_mode   = wr_stb_reg && wr_addr_reg == `PCM_CMD_MODE;
  wire wr_en     = wr_stb_reg && wr_addr_reg == `PCM_CMD_DET_CLASS_EN;
  wire wr_alloc  = wr_stb_reg && wr_addr_reg == `PCM_CMD_POWER_ALLOC;
  wire wr_reset  = wr_stb_reg && wr_addr_reg == `PCM_CMD_RESET;
  wire soft_rst  = rstpin_assert || (wr_reset && wr_data_reg[`PCM_RESET_ALL_BIT]);
  wire [NCH-1:0] port_rst = wr_reset ? wr_data_reg[`PCM_PORT_RESET_MSB:0] : '0;

  // presets from the strap captured at power-up
  wire        autonomous = sampled_reg && auto_cfg_reg != `PCM_AUTO_OPEN;
  wire        rom_auto   = autonomous && !SRAM_PROGRAMMED_I; // RULE_09 RULE_10
  wire [7:0]  pre_mode   = rom_auto ? `PCM_AUTO_MODE_PRESET : `PCM_MODE_RESET;
  wire [7:0]  pre_en     = rom_auto ? `PCM_AUTO_EN_PRESET : `PCM_EN_RESET;
  wire        sample_now = !sampled_reg && startup_reg == `PCM_STARTUP_CYCLES;
  wire        auto_new   = auto_sel != `PCM_AUTO_OPEN;
  wire [7:0]  alloc_pre  = (auto_sel == `PCM_AUTO_62K) ? `PCM_AUTO_ALLOC_30W : `PCM_ALLOC_RESET;

  // per-channel mode transitions
  logic [NCH-1:0] off_entry, cool_cancel, resume_next;
  always_comb
  begin
    mode_next   = mode_reg;
    en_next     = wr_en ? wr_data_reg : en_reg;
    alloc_next  = wr_alloc ? wr_data_reg : alloc_reg;
    resume_next = '0;
    if (sample_now)
    begin
      mode_next  = auto_new ? `PCM_AUTO_MODE_PRESET : `PCM_MODE_RESET; // RULE_05 RULE_04
      en_next    = auto_new ? `PCM_AUTO_EN_PRESET : `PCM_EN_RESET; // RULE_05
      alloc_next = alloc_pre; // RULE_05 RULE_06
    end
    else if (soft_rst)
    begin
      mode_next   = `PCM_MODE_RESET; // RULE_08
      en_next     = `PCM_EN_RESET;
      alloc_next  = alloc_reg;
      resume_next = rom_auto ? '1 : '0; // RULE_09
    end
    else if (wr_mode)
      mode_next = wr_data_reg; // RULE_07 RULE_12
    for (int n = 0; n < NCH; n++)
    begin
      if (resume_reg[n] && !soft_rst)
      begin
        mode_next[2*n +: 2] = pre_mode[2*n +: 2];
        en_next[n]          = pre_en[n];
        en_next[n+NCH]      = pre_en[n+NCH];
      end
      if (port_rst[n] || (rom_auto && wr_mode && wr_data_reg[2*n +: 2] == `PCM_MODE_OFF))
      begin
        mode_next[2*n +: 2] = `PCM_MODE_OFF;
        resume_next[n]      = rom_auto; // RULE_09
      end
      off_entry[n]   = mode_reg[2*n +: 2] != `PCM_MODE_OFF && mode_next[2*n +: 2] == `PCM_MODE_OFF; // RULE_17
      cool_cancel[n] = mode_reg[2*n +: 2] == `PCM_MODE_SEMI && !mode_next[2*n+1]; // RULE_19
      if (off_entry[n])
      begin
        en_next[n]     = 1'b0; // RULE_15
        en_next[n+NCH] = 1'b0; // RULE_15
      end
    end
  end

  // register update and registered outputs
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      mode_reg          <= `PCM_MODE_RESET;
      en_reg            <= `PCM_EN_RESET;
      alloc_reg         <= `PCM_ALLOC_RESET;
      auto_cfg_reg      <= `PCM_AUTO_OPEN;
      sampled_reg       <= 1'b0;
      startup_reg       <= 3'h0;
      resume_reg        <= '0;
      MODE_O            <= '0;
      DET_CLASS_EN_O    <= '0;
      POWER_ALLOC_O     <= 8'h00;
      AUTONOMOUS_O      <= 1'b0;
      PORT_ACTIVE_O     <= '0;
      OFF_CLEAR_O       <= '0;
      POWER_EVENT_SET_O <= '0;
      COOLDOWN_CANCEL_O <= '0;
    end
    else
    begin
      mode_reg      <= mode_next;
      en_reg        <= en_next;
      alloc_reg     <= alloc_next;
      resume_reg    <= resume_next;
      startup_reg   <= sampled_reg ? startup_reg : startup_reg + 3'h1;
      if (sample_now)
      begin
        auto_cfg_reg <= auto_sel; // RULE_08
        sampled_reg  <= 1'b1;
      end
      MODE_O            <= mode_next;
      DET_CLASS_EN_O    <= en_next;
      POWER_ALLOC_O     <= alloc_next; // RULE_06
      AUTONOMOUS_O      <= sample_now ? auto_new : autonomous; // RULE_04
      for (int n = 0; n < NCH; n++)
        PORT_ACTIVE_O[n] <= mode_next[2*n +: 2] != `PCM_MODE_OFF; // RULE_13
      OFF_CLEAR_O       <= off_entry; // RULE_14 RULE_15 RULE_16
      POWER_EVENT_SET_O <= {POWER_GOOD_I & off_entry, POWER_ENABLED_I & off_entry}; // RULE_18
      COOLDOWN_CANCEL_O <= cool_cancel; // RULE_19
    end
  end

endmodule

// *** test/pcm_chk.sv ***
`timescale 1ns/1ps
`include "pcm_map.svh"
module pcm_chk #(
  parameter int NCH = 4
) (
  input wire logic                         CLK_I,
  input wire logic                         RST_I,
  input wire logic                         SCL_I,
  input wire logic                         RESET_PIN_N_I,
  input wire logic [1:0]                   AUTO_SEL_I,
  input wire logic [NCH-1:0]               POWER_GOOD_I,
  input wire logic [NCH-1:0]               POWER_ENABLED_I,
  input wire logic                         SDA_OE_O,
  input wire pcm_pkg::pcm_mode_t [NCH-1:0] MODE_O,
  input wire logic [2*NCH-1:0]             DET_CLASS_EN_O,
  input wire logic [7:0]                   POWER_ALLOC_O,
  input wire logic                         AUTONOMOUS_O,
  input wire logic [NCH-1:0]               PORT_ACTIVE_O,
  input wire logic [NCH-1:0]               OFF_CLEAR_O,
  input wire logic [2*NCH-1:0]             POWER_EVENT_SET_O,
  input wire logic [NCH-1:0]               COOLDOWN_CANCEL_O
);
  import pcm_pkg::*;
  pcm_mode_t [NCH-1:0] prev_reg;
  logic [NCH-1:0]      off_now;
  logic [NCH-1:0]      went_off;
  logic [NCH-1:0]      cancel_exp;
  // last cycle's modes, so pulses are tied to mode edges and not levels
  always_ff @(posedge CLK_I or posedge RST_I)
    if (RST_I)
      prev_reg <= '0;
    else
      prev_reg <= MODE_O;
  // per channel edge decode
  for (genvar n = 0; n < NCH; n++)
  begin : g_ch
    assign off_now[n]    = MODE_O[n] == `PCM_MODE_OFF;
    assign went_off[n]   = off_now[n] && prev_reg[n] != `PCM_MODE_OFF;
    assign cancel_exp[n] = prev_reg[n] == `PCM_MODE_SEMI && !MODE_O[n][1];
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // presets land at most one cycle apart from the autonomous flag
  sequence s_preset;
    ##[0:1] MODE_O == 8'hFF && DET_CLASS_EN_O == 8'hFF
      && POWER_ALLOC_O == (AUTO_SEL_I == `PCM_AUTO_62K ? 8'h33 : 8'h00);
  endsequence
  off_clear_a: assert property ((|went_off) |-> (OFF_CLEAR_O & went_off) == went_off)
    else $error("no clear pulse on entry to off");
  clear_scope_a: assert property ((|OFF_CLEAR_O) |-> (OFF_CLEAR_O & ~off_now) == '0)
    else $error("clear pulse on a channel not off");
  off_inactive_a: assert property ((PORT_ACTIVE_O & off_now) == '0)
    else $error("off channel active");
  en_clear_a: assert property ((|went_off) |-> (DET_CLASS_EN_O & {went_off, went_off}) == '0)
    else $error("enables kept on entry to off");
  event_set_a: assert property (POWER_EVENT_SET_O == {OFF_CLEAR_O & $past(POWER_GOOD_I), OFF_CLEAR_O & $past(POWER_ENABLED_I)})
    else $error("power change events wrong");
  cool_cancel_a: assert property (COOLDOWN_CANCEL_O == cancel_exp)
    else $error("cooldown cancel wrong");
  sda_scl_low_a: assert property ($changed(SDA_OE_O) |-> !SCL_I)
    else $error("data line moved with clock high");
  auto_preset_a: assert property ($rose(AUTONOMOUS_O) |-> s_preset)
    else $error("autonomous presets wrong");
  soft_keep_a: assert property ($fell(RESET_PIN_N_I) |-> ($stable(POWER_ALLOC_O) && $stable(AUTONOMOUS_O)) [*8])
    else $error("soft reset re-sampled the select");
  soft_clear_a: assert property ($fell(RESET_PIN_N_I) |-> ##[2:10] MODE_O == 8'h00)
    else $error("soft reset left modes on");
endmodule
bind pcm_mode_control pcm_chk #(.NCH(NCH)) chk (.CLK_I, .RST_I, .SCL_I, .RESET_PIN_N_I, .AUTO_SEL_I,
  .POWER_GOOD_I, .POWER_ENABLED_I, .SDA_OE_O, .MODE_O, .DET_CLASS_EN_O, .POWER_ALLOC_O, .AUTONOMOUS_O,
  .PORT_ACTIVE_O, .OFF_CLEAR_O, .POWER_EVENT_SET_O, .COOLDOWN_CANCEL_O);

// *** test/pcm_host.sv ***
`timescale 1ns/1ps
// bus master; each line change is held long enough for the pin synchroniser
module pcm_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      pull_o
);
  logic lvl = 1'b1;
  initial
  begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end
  // clock and data never move together, so no false start or stop
  task automatic step(input logic c);
    @(posedge clk_i);
    scl_o  <= c;
    pull_o <= !lvl;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic bit_io(input logic d, output logic q);
    step(1'b0);
    lvl = d;
    step(1'b0);
    step(1'b1);
    q = sda_i;
  endtask
  task automatic start();
    step(1'b0);
    lvl = 1'b1;
    step(1'b0);
    step(1'b1);
    lvl = 1'b0;
    step(1'b1);
  endtask
  task automatic stop();
    step(1'b0);
    lvl = 1'b0;
    step(1'b0);
    step(1'b1);
    lvl = 1'b1;
    step(1'b1);
  endtask
  // last high releases the ninth bit: ack slot on writes, nack on reads
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(last, ack);
  endtask
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
  import pcm_pkg::*;
  logic            CLK_I = 1'b0;
  logic            RST_I, RESET_PIN_N_I, GROUP_STRAP_I, CONFIG_A_I, SRAM_PROGRAMMED_I;
  logic [3:0]      ADDR_PIN_I, POWER_GOOD_I, POWER_ENABLED_I, PORT_ACTIVE_O, OFF_CLEAR_O, COOLDOWN_CANCEL_O;
  logic [1:0]      AUTO_SEL_I;
  logic [7:0]      DET_CLASS_EN_O, POWER_ALLOC_O, POWER_EVENT_SET_O, rd_d;
  pcm_mode_t [3:0] MODE_O;
  logic            SCL_I, SDA_O, SDA_OE_O, AUTONOMOUS_O, pull, rd_v;
  logic [6:0]      dev;
  logic [31:0]     rnd = 32'ha427;
  int              bad_count = 0;
  int              n_checks = 0;
  logic [7:0]      ex_q[$];
  string           nm_q[$];
  logic [7:0]      mv [6] = '{8'hAA, 8'h55, 8'hAA, 8'h00, 8'hE4, 8'h1B};
  // pulled-up data wire
  wire             SDA_I = !pull && !(SDA_OE_O && !SDA_O);
  always #2 CLK_I = ~CLK_I;
  pcm_mode_control #(.NCH(4)) uut (.CLK_I, .RST_I, .SCL_I, .SDA_I, .SDA_O, .SDA_OE_O, .RESET_PIN_N_I, .ADDR_PIN_I,
    .GROUP_STRAP_I, .CONFIG_A_I, .AUTO_SEL_I, .SRAM_PROGRAMMED_I, .POWER_GOOD_I, .POWER_ENABLED_I, .MODE_O,
    .DET_CLASS_EN_O, .POWER_ALLOC_O, .AUTONOMOUS_O, .PORT_ACTIVE_O, .OFF_CLEAR_O, .POWER_EVENT_SET_O,
    .COOLDOWN_CANCEL_O);
  pcm_host host (.clk_i(CLK_I), .sda_i(SDA_I), .scl_o(SCL_I), .pull_o(pull));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic tally_and_finish();
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
    logic [7:0] q;
    logic       k;
    host.start();
    host.xfer({a, 1'b0}, 1'b1, q, k);
    host.xfer(r, 1'b1, q, k);
    host.xfer(d, 1'b1, q, k);
    host.stop();
  endtask
  // pointer set by a bare command write, then repeated start and one byte
  task automatic rd(input logic [6:0] a, input logic [7:0] r, input logic [7:0] e, input string nm);
    logic [7:0] q;
    logic       k;
    ex_q.push_back(e);
    nm_q.push_back(nm);
    host.start();
    host.xfer({a, 1'b0}, 1'b1, q, k);
    host.xfer(r, 1'b1, q, k);
    host.start();
    host.xfer({a, 1'b1}, 1'b1, q, k);
    host.xfer(8'hFF, 1'b1, q, k);
    host.stop();
    @(posedge CLK_I);
    rd_d <= q;
    rd_v <= 1'b1;
    @(posedge CLK_I);
    rd_v <= 1'b0;
  endtask
  // power-up; config A only on odd selects so config B sees a high group strap
  task automatic por(input logic [1:0] sel);
    rnd = xs(rnd);
    @(posedge CLK_I);
    RST_I      <= 1'b1;
    AUTO_SEL_I <= sel;
    ADDR_PIN_I <= rnd[3:0];
    CONFIG_A_I <= sel[0];
    dev = {2'b01, rnd[3:0], sel[0]};
    repeat (3) @(posedge CLK_I);
    RST_I <= 1'b0;
    repeat (20) @(posedge CLK_I);
  endtask
  task automatic shake();
    rnd = xs(rnd);
    @(posedge CLK_I);
    POWER_GOOD_I    <= rnd[3:0];
    POWER_ENABLED_I <= rnd[7:4];
  endtask
  task automatic pin_reset();
    @(posedge CLK_I);
    RESET_PIN_N_I <= 1'b0;
    repeat (8) @(posedge CLK_I);
    RESET_PIN_N_I <= 1'b1;
    repeat (20) @(posedge CLK_I);
  endtask
  // read results against the oldest note
  always @(posedge CLK_I)
    if (rd_v)
    begin
      n_checks++;
      if (rd_d !== ex_q[0])
      begin
        bad_count++;
        $display("unexpected %s: expected %h seen %h", nm_q[0], ex_q[0], rd_d);
      end
      void'(ex_q.pop_front());
      void'(nm_q.pop_front());
    end
  // hang guard: a stuck run still reaches the verdict
  initial
  begin
    repeat (100000) @(posedge CLK_I);
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    {RST_I, RESET_PIN_N_I, GROUP_STRAP_I} = 3'b111;
    {CONFIG_A_I, SRAM_PROGRAMMED_I, rd_v, AUTO_SEL_I} = '0;
    {ADDR_PIN_I, POWER_GOOD_I, POWER_ENABLED_I} = '0;
    for (int s = 0; s < 3; s++)
    begin
      por(s[1:0]);
      rd(dev, 8'h11, {1'b0, ADDR_PIN_I, s[0], 2'b00}, "strap");
      rd(dev, 8'h12, s ? 8'hFF : 8'h00, "mode");
      rd(dev, 8'h14, s ? 8'hFF : 8'h00, "enables");
      rd(dev, 8'h29, s[1] ? 8'h33 : 8'h00, "alloc");
    end
    wr(dev, 8'h11, 8'hFF);
    rd(dev, 8'h11, {1'b0, ADDR_PIN_I, 3'b000}, "strap after write");
    rd(dev ^ 7'h08, 8'h29, 8'hFF, "foreign address");
    rd(dev, 8'h7E, 8'h00, "unmapped");
    rd(dev, 8'h1A, 8'h00, "reset reg");
    AUTO_SEL_I <= 2'b00;
    // rom autonomous: every kind of turn-off comes back by itself
    for (int k = 0; k < 4; k++)
    begin
      shake();
      case (k)
        0: wr(dev, 8'h12, 8'h00);
        1: pin_reset();
        2: wr(dev, 8'h1A, 8'h80);
        default: wr(dev, 8'h1A, 8'h0F);
      endcase
      rd(dev, 8'h12, 8'hFF, "rom restart");
    end
    rd(dev, 8'h29, 8'h33, "alloc kept");
    @(posedge CLK_I);
    SRAM_PROGRAMMED_I <= 1'b1;
    wr(7'h7F, 8'h12, 8'h00);
    rd(dev, 8'h12, 8'h00, "sram stays off");
    rd(dev, 8'h14, 8'h00, "off enables");
    for (int k = 0; k < 6; k++)
    begin
      shake();
      wr(dev, 8'h12, mv[k]);
      rd(dev, 8'h12, mv[k], "mode walk");
    end
    wr(dev, 8'h14, 8'hFF);
    wr(dev, 8'h12, 8'h18);
    rd(dev, 8'h14, 8'hEE, "one channel cleared");
    wr(dev, 8'h12, 8'hFF);
    wr(dev, 8'h1A, 8'h02);
    rd(dev, 8'h12, 8'hF3, "port reset");
    wr(dev, 8'h1A, 8'h80);
    rd(dev, 8'h12, 8'h00, "reset all");
    rd(dev, 8'h29, 8'h33, "alloc after reset all");
    @(posedge CLK_I);
    tally_and_finish();
  end
endmodule
